// [dv/pss_smi_host.sv]
// Host model that receives the SMI pulses and counts them.
// Assumes the SMI output is a one-cycle registered pulse on the core clock.
`timescale 1ns/1ps
module pss_smi_host (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        smi_i,
  output logic      [31:0] smi_count_o
);
  // Each pulse is one SMI entry, so the handler sees one request per pulse, even when several events share it.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      smi_count_o <= 32'h0;
    end else if (smi_i) begin
      smi_count_o <= smi_count_o + 32'h1;
    end
  end
endmodule

// [dv/pss_smi_source_bench.sv]
// Self-checking bench for the SMI source block: register bus, gating, status set and clear.
// Assumes the design package is compiled first and a host model counts SMI pulses.
`timescale 1ns/1ps
module pss_smi_source_bench;
  import pss_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, smi_count;
  logic ack, smi;
  pss_events_t ev = '0, e;
  logic [7:0] trap_en = 8'h00, timer_en = 8'h00, v;
  logic [31:0] expq[$];
  int seed = 8414, fail_count = 0, checked = 0;
  pss_smi_source DUT (.core_clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .events_i(ev), .trap_enable_i(trap_en), .timer_enable_i(timer_en),
    .system_mgmt_interrupt_o(smi));
  pss_smi_host host (.core_clk_i(clk), .reset_n_i(rst_n), .smi_i(smi), .smi_count_o(smi_count));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Holds the request until ack is sampled high, then releases for at least one cycle.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [7:0] exp);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat <= {24'h0, d};
    if (!w) begin
      expq.push_back({24'h0, exp});
    end
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  // Reads are compared in arrival order against the oldest queued note.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) begin
        check(rdat, 32'hFFFFFFFF);
      end else begin
        check(rdat, expq.pop_front());
      end
    end
  end
  // Events are held long enough for the synchroniser to see both edges.
  task automatic pulse(input pss_events_t p);
    @(posedge clk);
    ev <= p;
    repeat (8) @(posedge clk);
    ev <= '0;
    repeat (8) @(posedge clk);
  endtask
  task automatic smi_case(input logic [7:0] idx, input logic [7:0] en, input logic [7:0] glb,
                          input pss_events_t p, input logic [31:0] exp);
    logic [31:0] c0;
    bus(1'b1, idx, en, 8'h00);
    bus(1'b1, IDX_GLOBAL_CTRL, glb, 8'h00);
    bus(1'b0, IDX_GLOBAL_CTRL, 8'h00, glb & 8'h03);
    c0 = smi_count;
    pulse(p);
    check(smi_count - c0, exp);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, IDX_IRQ_LOW_EN, 8'h00, 8'h00);
    bus(1'b0, IDX_IRQ_HIGH_EN, 8'h00, 8'h00);
    bus(1'b0, IDX_DMA_EN, 8'h00, 8'h00);
    bus(1'b0, IDX_TRAP_STATUS, 8'h00, 8'h00);
    bus(1'b0, IDX_TIMER_STATUS, 8'h00, 8'h00);
    bus(1'b0, 8'h7F, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      bus(1'b1, IDX_IRQ_LOW_EN + 8'(i), v, 8'h00);
      bus(1'b0, IDX_IRQ_LOW_EN + 8'(i), 8'h00, v);
    end
    e = '0;
    e.irq_line[0] = 1'b1;
    smi_case(IDX_IRQ_LOW_EN, 8'h01, 8'h00, e, 0);
    smi_case(IDX_IRQ_LOW_EN, 8'h01, 8'h01, e, 1);
    e = '0;
    e.irq_line[9] = 1'b1;
    smi_case(IDX_IRQ_HIGH_EN, 8'h00, 8'h01, e, 0);
    smi_case(IDX_IRQ_HIGH_EN, 8'h02, 8'h01, e, 1);
    e = '0;
    e.any_irq = 1'b1;
    smi_case(IDX_IRQ_LOW_EN, 8'h04, 8'h01, e, 1);
    smi_case(IDX_IRQ_LOW_EN, 8'hFB, 8'h01, e, 0);
    e = '0;
    e.any_dma = 1'b1;
    smi_case(IDX_DMA_EN, 8'h10, 8'h02, e, 1);
    smi_case(IDX_DMA_EN, 8'h10, 8'h01, e, 0);
    e = '0;
    e.dma_line[4] = 1'b1;
    smi_case(IDX_DMA_EN, 8'h10, 8'h02, e, 0);
    e = '0;
    e.dma_line[7] = 1'b1;
    smi_case(IDX_DMA_EN, 8'h80, 8'h02, e, 1);
    trap_en <= 8'h0F;
    e = '0;
    e.trap = 8'hFF;
    pulse(e);
    bus(1'b0, IDX_TRAP_STATUS, 8'h00, 8'h0F);
    bus(1'b1, IDX_TRAP_STATUS, 8'h00, 8'h00);
    bus(1'b0, IDX_TRAP_STATUS, 8'h00, 8'h0F);
    bus(1'b1, IDX_TRAP_STATUS, 8'h05, 8'h00);
    bus(1'b0, IDX_TRAP_STATUS, 8'h00, 8'h0A);
    timer_en <= 8'hFF;
    e = '0;
    e.timer = 8'hFF;
    pulse(e);
    bus(1'b0, IDX_TIMER_STATUS, 8'h00, 8'hFF);
    bus(1'b0, IDX_TIMER_STATUS, 8'h00, 8'hFC);
    bus(1'b1, IDX_TIMER_STATUS, 8'h33, 8'h00);
    bus(1'b0, IDX_TIMER_STATUS, 8'h00, 8'hCC);
    bus(1'b1, IDX_TIMER_STATUS, 8'hFF, 8'h00);
    bus(1'b0, IDX_TIMER_STATUS, 8'h00, 8'h00);
    repeat (4) @(posedge clk);
    check(32'(expq.size()), 32'h0);
    complete_run();
  end
endmodule

// [include/pss_pkg.sv]
// Package for the SMI source enable and status block: offsets, field positions, reset values.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
package pss_pkg;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_IRQ_LOW_EN   = 8'h73;
  localparam logic [7:0] IDX_IRQ_HIGH_EN  = 8'h74;
  localparam logic [7:0] IDX_DMA_EN       = 8'h75;
  localparam logic [7:0] IDX_TRAP_STATUS  = 8'h76;
  localparam logic [7:0] IDX_TIMER_STATUS = 8'h77;
  // Extra register holding the global request enables and the SMI level.
  localparam logic [7:0] IDX_GLOBAL_CTRL  = 8'h7C;

  localparam int ADDR_W = 10;

  localparam logic [7:0] RST_REG8 = 8'h00;

  // Field positions.
  localparam int BIT_ANY_IRQ      = 2;
  localparam int BIT_ANY_DMA      = 4;
  localparam int BIT_PCI_MASTER   = 3;
  localparam int BIT_NMI          = 2;
  localparam int BIT_IO_TRAP2     = 1;
  localparam int BIT_IO_TRAP1     = 0;
  localparam int BIT_GLB_IRQ_EN   = 0;
  localparam int BIT_GLB_DMA_EN   = 1;
  localparam int BIT_GLB_SMI_LVL  = 7;

  // Timer status bits clear by writing one; the two I/O trap bits clear on read.
  localparam logic [7:0] TIMER_W1C_MASK = 8'hFC;
  localparam logic [7:0] TIMER_ROC_MASK = 8'h03;
  // Channel 4 of the DMA enable is the any-request enable, not a channel.
  localparam logic [7:0] DMA_CHAN_MASK  = 8'hEF;
  localparam logic [7:0] IRQ_LINE_MASK  = 8'hFB;

  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [15:0] irq_line;
    logic        any_irq;
    logic [7:0]  dma_line;
    logic        any_dma;
    logic [7:0]  trap;
    logic [7:0]  timer;
  } pss_events_t;

endpackage

// [src/pss_smi_source.sv]
// SMI source enable and status registers with Wishbone classic slave and SMI output.
// Assumes event inputs are asynchronous levels; a rising edge is one event.
//
// Overview of operation
// R01: Enable 0x73 bits 7..3,1,0 let interrupt lines 7..3,1,0 raise SMI.
// R02: Enable 0x73 bit 2 lets the any-interrupt request raise SMI.
// R03: Enable 0x74 bits 7..0 let interrupt lines 15..8 raise SMI.
// R04: Enable 0x75 bits 7..5,3..0 let DMA channels 7..5,3..0 raise SMI.
// R05: Enable 0x75 bit 4 lets any DMA request raise SMI.
// R06: All five registers reset to zero so nothing raises SMI; trap and timer events still do while trap_enable_i or timer_enable_i is set.
// R07: Status 0x76 records the eight access-trap causes.
// R08: Writing one clears a clearable status bit; writing zero leaves it.
// R09: Status 0x77 bits 7..4 record the four timer timeouts.
// R10: Status 0x77 bit 3 is PCI master request, bit 2 is NMI.
// R11: Status 0x77 bits 1 and 0 are programmable I/O traps 2 and 1.
// R12: The two I/O trap bits clear themselves when the register is read.
// R13: Interrupt enables act only while the global interrupt enable is set.
// R14: DMA enables act only while the global DMA enable is set.
// R15: A status bit sets only on its enabled source and stays until cleared.
// R16: SMI output rises when any enabled source event occurs.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module pss_smi_source (
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [pss_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire pss_pkg::pss_events_t       events_i,
  input  wire logic [7:0]                 trap_enable_i,
  input  wire logic [7:0]                 timer_enable_i,
  output logic                            system_mgmt_interrupt_o
);
  import pss_pkg::*;

  localparam int EV_W = $bits(pss_events_t);

  logic [7:0]  irq_low_en_reg;
  logic [7:0]  irq_high_en_reg;
  logic [7:0]  dma_en_reg;
  logic [7:0]  trap_status_reg;
  logic [7:0]  timer_status_reg;
  logic [7:0]  global_ctrl_reg;
  logic [EV_W-1:0] sync_reg [SYNC_STAGES];
  logic [EV_W-1:0] prev_reg;
  pss_events_t level;
  pss_events_t rise;
  logic        req;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic [7:0]  wdata;
  logic [7:0]  irq_low_hit;
  logic [7:0]  irq_high_hit;
  logic [7:0]  dma_hit;
  logic [7:0]  trap_hit;
  logic [7:0]  timer_hit;
  logic [7:0]  trap_clr;
  logic [7:0]  timer_clr;
  logic        smi_next;

  // Three-stage synchroniser; an edge counts when stages two and three agree.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_reg[i] <= '0;
      end
      prev_reg <= '0;
    end else begin
      sync_reg[0] <= events_i;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_reg[i] <= sync_reg[i-1];
      end
      if (sync_reg[1] == sync_reg[2]) begin
        prev_reg <= sync_reg[2];
      end
    end
  end

  always_comb begin
    level = (sync_reg[1] == sync_reg[2]) ? pss_events_t'(sync_reg[2]) : pss_events_t'(prev_reg);
    rise  = pss_events_t'(level & ~prev_reg);
  end

  // Bus decode; only byte lane 0 carries a register.
  // A write lands on the edge that sees ack high, which is when the master lets go of it.
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx   = wb_adr_i[ADDR_W-1:2];
  assign wr    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd    = req && !wb_we_i;
  assign wdata = wb_dat_i[7:0];

  // Per-source hits after gating by local enables, and by global enables for interrupt and DMA sources.
  always_comb begin
    irq_low_hit  = '0;
    irq_high_hit = '0;
    dma_hit      = '0;
    if (global_ctrl_reg[BIT_GLB_IRQ_EN]) begin  // see R13
      irq_low_hit  = {rise.irq_line[7:3], 1'b0, rise.irq_line[1:0]}
                     & irq_low_en_reg & IRQ_LINE_MASK;  // see R01
      irq_low_hit[BIT_ANY_IRQ] = rise.any_irq & irq_low_en_reg[BIT_ANY_IRQ];  // see R02
      irq_high_hit = rise.irq_line[15:8] & irq_high_en_reg;  // see R03
    end
    if (global_ctrl_reg[BIT_GLB_DMA_EN]) begin  // see R14
      dma_hit = rise.dma_line & dma_en_reg & DMA_CHAN_MASK;  // see R04
      dma_hit[BIT_ANY_DMA] = rise.any_dma & dma_en_reg[BIT_ANY_DMA];  // see R05
    end
    trap_hit  = rise.trap & trap_enable_i;
    timer_hit = rise.timer & timer_enable_i;
  end

  always_comb begin
    trap_clr  = (wr && idx == IDX_TRAP_STATUS) ? wdata : 8'h00;  // see R08
    timer_clr = '0;
    if (wr && idx == IDX_TIMER_STATUS) begin
      timer_clr = wdata & TIMER_W1C_MASK;  // see R08
    end
    if (rd && idx == IDX_TIMER_STATUS) begin
      timer_clr = timer_clr | TIMER_ROC_MASK;  // see R12
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      irq_low_en_reg  <= RST_REG8;  // see R06
      irq_high_en_reg <= RST_REG8;
      dma_en_reg      <= RST_REG8;
      global_ctrl_reg <= RST_REG8;
    end else if (wr) begin
      unique case (idx)
        IDX_IRQ_LOW_EN:  irq_low_en_reg  <= wdata;
        IDX_IRQ_HIGH_EN: irq_high_en_reg <= wdata;
        IDX_DMA_EN:      dma_en_reg      <= wdata;
        IDX_GLOBAL_CTRL: global_ctrl_reg <= {1'b0, 5'h00, wdata[BIT_GLB_DMA_EN:0]};
        default:         ;
      endcase
    end
  end

  // A new event in the clearing cycle wins, so no cause is lost.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      trap_status_reg  <= RST_REG8;  // see R06
      timer_status_reg <= RST_REG8;
    end else begin
      trap_status_reg  <= (trap_status_reg & ~trap_clr) | trap_hit;  // see R07, R15
      timer_status_reg <= (timer_status_reg & ~timer_clr) | timer_hit;  // see R09, R10, R11
    end
  end

  assign smi_next = |{irq_low_hit, irq_high_hit, dma_hit, trap_hit, timer_hit};

  // The output pulses for one cycle per cycle with any enabled event, however many share it; the handler reads status for trap and timer causes.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      system_mgmt_interrupt_o <= 1'b0;
    end else begin
      system_mgmt_interrupt_o <= smi_next;  // see R16
    end
  end

  // Every access is answered one cycle later; unmapped indexes read zero and ignore writes.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= '0;
      if (rd) begin
        unique case (idx)
          IDX_IRQ_LOW_EN:   wb_dat_o <= {24'h000000, irq_low_en_reg};
          IDX_IRQ_HIGH_EN:  wb_dat_o <= {24'h000000, irq_high_en_reg};
          IDX_DMA_EN:       wb_dat_o <= {24'h000000, dma_en_reg};
          IDX_TRAP_STATUS:  wb_dat_o <= {24'h000000, trap_status_reg};
          IDX_TIMER_STATUS: wb_dat_o <= {24'h000000, timer_status_reg};
          IDX_GLOBAL_CTRL:  wb_dat_o <= {24'h000000, global_ctrl_reg[7:1],
                                         global_ctrl_reg[0]} |
                                        {24'h000000, system_mgmt_interrupt_o, 7'h00};
          default:          wb_dat_o <= '0;
        endcase
      end
    end
  end

  property p_reset_clear;
    @(posedge core_clk_i) !reset_n_i |=> (irq_low_en_reg == 8'h00 && trap_status_reg == 8'h00
      && timer_status_reg == 8'h00 && !system_mgmt_interrupt_o);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset left state set"); // see R06

  // A request is taken when the strobe is up and no answer is pending.
  sequence s_bus_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // The answer is a single acknowledge cycle; a second one would start a phantom access.
  sequence s_bus_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack_one;
    @(posedge core_clk_i) disable iff (!reset_n_i) s_bus_taken |=> s_bus_answer;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("Ack not single cycle");

  property p_w1c;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (wr && idx == IDX_TRAP_STATUS && trap_hit == 8'h00)
      |=> (trap_status_reg & $past(wdata)) == 8'h00;
  endproperty
  a_w1c: assert property (p_w1c) else $error("Write one did not clear"); // see R08

  property p_w0_keep;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (wr && idx == IDX_TRAP_STATUS && trap_hit == 8'h00)
      |=> (trap_status_reg & ~$past(wdata)) == ($past(trap_status_reg) & ~$past(wdata));
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("Write zero changed status"); // see R08

  property p_read_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (rd && idx == IDX_TIMER_STATUS && timer_hit[1:0] == 2'b00)
      |=> timer_status_reg[1:0] == 2'b00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Trap bits kept after read"); // see R12

  property p_smi_cause;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      system_mgmt_interrupt_o |-> $past(smi_next);
  endproperty
  a_smi_cause: assert property (p_smi_cause) else $error("SMI without cause"); // see R16

  property p_irq_gate;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !global_ctrl_reg[BIT_GLB_IRQ_EN] |-> (irq_low_hit == 8'h00 && irq_high_hit == 8'h00);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("IRQ hit with global off"); // see R13

  property p_dma_gate;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (global_ctrl_reg[BIT_GLB_DMA_EN] && rise.any_dma && dma_en_reg[BIT_ANY_DMA])
      |=> system_mgmt_interrupt_o;
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("Any DMA did not raise SMI"); // see R05

  property p_sticky;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (timer_status_reg[7] && timer_clr[7] == 1'b0) |=> timer_status_reg[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Status bit dropped alone"); // see R15

  property p_set_on_hit;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      trap_hit[0] |=> trap_status_reg[0];
  endproperty
  a_set_on_hit: assert property (p_set_on_hit) else $error("Trap hit not recorded"); // see R07

  property p_reset_rest;
    @(posedge core_clk_i) !reset_n_i |=> (irq_high_en_reg == 8'h00 && dma_en_reg == 8'h00
      && global_ctrl_reg == 8'h00 && !wb_ack_o);
  endproperty
  a_reset_rest: assert property (p_reset_rest) else $error("Reset left an enable set"); // see R06

  property p_irq_low_line;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (global_ctrl_reg[BIT_GLB_IRQ_EN] && |(rise.irq_line[7:0] & irq_low_en_reg & IRQ_LINE_MASK))
      |=> system_mgmt_interrupt_o;
  endproperty
  a_irq_low_line: assert property (p_irq_low_line) else $error("Low line no SMI"); // see R01

  property p_any_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (global_ctrl_reg[BIT_GLB_IRQ_EN] && rise.any_irq && irq_low_en_reg[BIT_ANY_IRQ])
      |=> system_mgmt_interrupt_o;
  endproperty
  a_any_irq: assert property (p_any_irq) else $error("Any IRQ did not raise SMI"); // see R02

  property p_irq_high;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (global_ctrl_reg[BIT_GLB_IRQ_EN] && |(rise.irq_line[15:8] & irq_high_en_reg))
      |=> system_mgmt_interrupt_o;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("High IRQ line no SMI"); // see R03

  property p_dma_line;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (global_ctrl_reg[BIT_GLB_DMA_EN] && |(rise.dma_line & dma_en_reg & DMA_CHAN_MASK))
      |=> system_mgmt_interrupt_o;
  endproperty
  a_dma_line: assert property (p_dma_line) else $error("DMA channel no SMI"); // see R04

  property p_dma_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !global_ctrl_reg[BIT_GLB_DMA_EN] |-> dma_hit == 8'h00;
  endproperty
  a_dma_off: assert property (p_dma_off) else $error("DMA hit with global off"); // see R14

  property p_timer_set;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      timer_hit != 8'h00
      |=> (timer_status_reg & $past(timer_hit)) == $past(timer_hit);
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("Timer cause lost"); // see R09, R10, R11

  property p_timer_w1c;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (wr && idx == IDX_TIMER_STATUS && timer_hit == 8'h00)
      |=> (timer_status_reg & $past(wdata) & TIMER_W1C_MASK) == 8'h00;
  endproperty
  a_timer_w1c: assert property (p_timer_w1c) else $error("Timer write one kept"); // see R08

  property p_trap_fresh;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      1'b1 |=> (trap_status_reg & ~$past(trap_status_reg) & ~$past(trap_hit)) == 8'h00;
  endproperty
  a_trap_fresh: assert property (p_trap_fresh) else $error("Trap set with no hit"); // see R15

  property p_timer_fresh;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      1'b1 |=> (timer_status_reg & ~$past(timer_status_reg) & ~$past(timer_hit)) == 8'h00;
  endproperty
  a_timer_fresh: assert property (p_timer_fresh) else $error("Timer set with no hit"); // see R15

  property p_smi_follow;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      smi_next |=> system_mgmt_interrupt_o;
  endproperty
  a_smi_follow: assert property (p_smi_follow) else $error("Enabled event lost SMI"); // see R16

  property p_data_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !wb_ack_o |-> wb_dat_o == 32'h00000000;
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("Read data outside ack");

  // Each trap cause is checked on its own, so one dropped bit cannot hide behind another.
  for (genvar b = 0; b < 8; b++) begin : g_trap_bit
    property p_trap_hold;
      @(posedge core_clk_i) disable iff (!reset_n_i)
        (trap_status_reg[b] && !trap_clr[b]) |=> trap_status_reg[b];
    endproperty
    a_trap_hold: assert property (p_trap_hold) else $error("Trap status bit dropped"); // see R15
  end

endmodule
